// ===== core/irqrf_pkg.sv
// Purpose: Shared constants and types for the interrupt sources block
// Assumes: 8-bit register port, one system clock
// Notes:   Register values are 8 bits, unused bits read as zero
package irqrf_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_RCC   = 3'h0;
  localparam logic [2:0] OFF_MAIN  = 3'h1;
  localparam logic [2:0] OFF_SEC   = 3'h2;
  localparam logic [2:0] OFF_THIRD = 3'h3;
  localparam logic [2:0] OFF_CPEA  = 3'h4;
  localparam logic [2:0] OFF_CPEB  = 3'h5;
  localparam logic [2:0] OFF_STKP  = 3'h6;
  // reset_cause_control fields
  localparam int B_PRIO = 7;
  localparam int B_SBOR = 6;
  localparam int B_RI   = 4;
  localparam int B_TO   = 3;
  localparam int B_PD   = 2;
  localparam int B_POR  = 1;
  localparam int B_BOR  = 0;
  // irq_control_main fields
  localparam int B_GIE  = 7;
  localparam int B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int B_TOE  = 5;
  localparam int B_E0E  = 4;
  localparam int B_PCE  = 3;
  localparam int B_TOF  = 2;
  localparam int B_E0F  = 1;
  localparam int B_PCF  = 0;
  // irq_control_second fields, edge select at 6..4 for pins 0..2
  localparam int B_EDG0 = 6;
  localparam int B_TOP  = 2;
  localparam int B_PCP  = 0;
  // irq_control_third fields
  localparam int B_E2P  = 7;
  localparam int B_E1P  = 6;
  localparam int B_E2E  = 4;
  localparam int B_E1E  = 3;
  localparam int B_E2F  = 1;
  localparam int B_E1F  = 0;
  localparam logic [7:0] RCC_RESET   = 8'h5e;
  localparam logic [7:0] RCC_MASK    = 8'hdf;
  localparam logic [7:0] MAIN_RESET  = 8'h00;
  localparam logic [7:0] SEC_RESET   = 8'h75;
  localparam logic [7:0] SEC_MASK    = 8'h75;
  localparam logic [7:0] THIRD_RESET = 8'hc0;
  localparam logic [7:0] THIRD_MASK  = 8'hdb;
  localparam logic [1:0] BOR_MODE_SW = 2'h1;
  localparam logic [7:0] BYTE_ONES   = 8'hff;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } irqrf_req_s;

  typedef struct packed {
    logic [7:0] accum;
    logic [7:0] status;
    logic [7:0] bank;
  } irqrf_ctx_s;
endpackage : irqrf_pkg

// ===== core/irqrf_top.sv
// Purpose: Interrupt sources, reset-cause flags and context save
// Assumes: Pins asynchronous, core and timer signals on clock
// Notes:   rst is the power-on reset; other resets arrive as pulses
// Summary of operation
// - Bit 7 enables two priority levels, reset 0
// - Software brown-out enable acts only in mode 01
// - Software brown-out enable resets to 1 when selected
// - Reset instruction clears flag; firmware or power-on sets
// - Watchdog flag set by power-up/clear/sleep, cleared on expiry
// - Power-down flag set by power-up/clear, cleared by sleep
// - Power-on status reads 0; software then sets it
// - Brown-out status reads 0 after brown-out; firmware sets
// - Edge select 1 rising, 0 falling per pin
// - Valid edge sets flag; enable gates request
// - Enabled external interrupt wakes; vector if global enable, low priority pins also need peripheral enable
// - Pins 1,2 own priority; pin 0 always high
// - Timer flag on 8-bit or 16-bit wrap
// - Timer interrupt gated by enable, own priority bit
// - Enabled port pin change sets flag, enable gates it
// - Port change priority from its priority bit
// - Interrupt entry pushes return address on stack
// - Interrupt entry copies accumulator, status, bank to shadow
// - Without priorities, peripherals also need peripheral enable
`timescale 1ns/100ps
module irqrf_top
  import irqrf_pkg::*;
#(
  parameter int PC_W        = 21,
  parameter int STACK_DEPTH = 31
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire irqrf_req_s        bus_req,
  output logic [7:0]             bus_rdata,
  input  wire logic [1:0]        brownout_mode_field,
  input  wire logic              reset_instr_exec,
  input  wire logic              watchdog_expiry,
  input  wire logic              watchdog_clear_instr,
  input  wire logic              sleep_instr,
  input  wire logic              brownout_reset,
  input  wire logic [2:0]        ext_irq_pins,
  input  wire logic [7:0]        port_a_pins,
  input  wire logic [7:0]        port_b_pins,
  input  wire logic              port_a_access,
  input  wire logic              port_b_access,
  input  wire logic [15:0]       timer_count,
  input  wire logic              timer_wide_mode,
  input  wire logic              periph_high_pending,
  input  wire logic              periph_low_pending,
  input  wire logic              irq_entry,
  input  wire logic              irq_return,
  input  wire logic [PC_W-1:0]   return_pc,
  input  wire irqrf_ctx_s        core_ctx,
  output logic                   irq_high,
  output logic                   irq_low,
  output logic                   wake_request,
  output logic                   sw_brownout_active,
  output logic [PC_W-1:0]        stack_top_pc,
  output irqrf_ctx_s             shadow_ctx
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);

  function automatic logic hit(input logic [ADDR_W-1:0] off, input logic stb);
    hit = stb && (bus_req.addr == off);
  endfunction : hit

  // Pin synchronisers: three stages, level follows when 2nd and 3rd agree
  logic [18:0] pin_s1;
  logic [18:0] pin_s2;
  logic [18:0] pin_s3;
  logic [18:0] pin_lvl;
  logic [18:0] next_pin_lvl;
  logic [2:0]  ext_edge;
  logic [7:0]  cpe_a;
  logic [7:0]  cpe_b;
  logic [7:0]  seen_a;
  logic [7:0]  seen_b;
  logic [7:0]  next_cpe_a;
  logic [7:0]  next_cpe_b;
  logic [7:0]  next_seen_a;
  logic [7:0]  next_seen_b;
  logic [15:0] timer_prev;
  logic        timer_wrap;
  logic        port_mismatch;

  always_comb
  begin
    next_pin_lvl = (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_lvl & (pin_s2 ^ pin_s3));
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_s1  <= '0;
      pin_s2  <= '0;
      pin_s3  <= '0;
      pin_lvl <= '0;
    end
    else
    begin
      pin_s1  <= {port_b_pins, port_a_pins, ext_irq_pins};
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pin_lvl <= next_pin_lvl;
    end
  end

  logic [7:0] rcc;
  logic [7:0] main;
  logic [7:0] sec;
  logic [7:0] third;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_edge
      // Edge select picks rising or falling
      assign ext_edge[gi] = sec[B_EDG0-gi] ? (next_pin_lvl[gi] & ~pin_lvl[gi])
                                           : (~next_pin_lvl[gi] & pin_lvl[gi]);
    end
  endgenerate

  // Mismatch against the value latched at the last port access
  always_comb
  begin
    port_mismatch = |(((pin_lvl[10:3] ^ seen_a) & cpe_a) |
                      ((pin_lvl[18:11] ^ seen_b) & cpe_b));
    timer_wrap = timer_wide_mode ? (timer_prev == 16'hffff && timer_count == 16'h0000)
                 : (timer_prev[7:0] == BYTE_ONES && timer_count[7:0] == BYTE_ZERO);
    next_cpe_a  = hit(OFF_CPEA, bus_req.wr) ? bus_req.wdata : cpe_a;
    next_cpe_b  = hit(OFF_CPEB, bus_req.wr) ? bus_req.wdata : cpe_b;
    next_seen_a = port_a_access ? pin_lvl[10:3] : seen_a;
    next_seen_b = port_b_access ? pin_lvl[18:11] : seen_b;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cpe_a      <= '0;
      cpe_b      <= '0;
      seen_a     <= '0;
      seen_b     <= '0;
      timer_prev <= '0;
    end
    else
    begin
      cpe_a      <= next_cpe_a;
      cpe_b      <= next_cpe_b;
      seen_a     <= next_seen_a;
      seen_b     <= next_seen_b;
      timer_prev <= timer_count;
    end
  end

  // Control and flag registers; hardware events win over software writes
  logic [7:0] next_rcc;
  logic [7:0] next_main;
  logic [7:0] next_sec;
  logic [7:0] next_third;
  logic [7:0] rcc_view;

  always_comb
  begin
    rcc_view = rcc;
    if (brownout_mode_field != BOR_MODE_SW)
      rcc_view[B_SBOR] = 1'b0;
    next_rcc = rcc;
    if (hit(OFF_RCC, bus_req.wr))
    begin
      next_rcc[B_PRIO] = bus_req.wdata[B_PRIO];
      next_rcc[B_SBOR] = bus_req.wdata[B_SBOR];
      next_rcc[B_RI]   = bus_req.wdata[B_RI];
      next_rcc[B_POR]  = bus_req.wdata[B_POR];
      next_rcc[B_BOR]  = bus_req.wdata[B_BOR];
    end
    if (watchdog_clear_instr)
    begin
      next_rcc[B_TO] = 1'b1;
      next_rcc[B_PD] = 1'b1;
    end
    if (sleep_instr)
    begin
      next_rcc[B_TO] = 1'b1;
      next_rcc[B_PD] = 1'b0;
    end
    if (watchdog_expiry)
      next_rcc[B_TO] = 1'b0;
    if (reset_instr_exec)
      next_rcc[B_RI] = 1'b0;
    if (brownout_reset)
      next_rcc[B_BOR] = 1'b0;

    next_main  = main;
    next_sec   = sec;
    next_third = third;
    if (hit(OFF_MAIN, bus_req.wr))
      next_main = bus_req.wdata;
    if (hit(OFF_SEC, bus_req.wr))
      next_sec = bus_req.wdata & SEC_MASK;
    if (hit(OFF_THIRD, bus_req.wr))
      next_third = bus_req.wdata & THIRD_MASK;
    // Flags are set regardless of interrupt enables (port change still needs its pin enables); software alone clears them
    if (ext_edge[0])
      next_main[B_E0F] = 1'b1;
    if (ext_edge[1])
      next_third[B_E1F] = 1'b1;
    if (ext_edge[2])
      next_third[B_E2F] = 1'b1;
    if (timer_wrap)
      next_main[B_TOF] = 1'b1;
    // Stays set while a mismatch persists
    if (port_mismatch)
      next_main[B_PCF] = 1'b1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rcc   <= RCC_RESET & ~(8'h1 << B_POR) & ~(8'h1 << B_BOR);
      main  <= MAIN_RESET;
      sec   <= SEC_RESET;
      third <= THIRD_RESET;
    end
    else
    begin
      rcc   <= next_rcc & RCC_MASK;
      main  <= next_main;
      sec   <= next_sec;
      third <= next_third;
    end
  end

  assign sw_brownout_active = rcc_view[B_SBOR];

  // Request routing
  logic [3:0] act;
  logic [3:0] act_prio;
  logic       any_high;
  logic       any_low;

  always_comb
  begin
    act[0] = main[B_E0F] & main[B_E0E];
    act[1] = third[B_E1F] & third[B_E1E];
    act[2] = third[B_E2F] & third[B_E2E];
    act[3] = (main[B_TOF] & main[B_TOE]) | 1'b0;
    act_prio = {sec[B_TOP], third[B_E2P], third[B_E1P], 1'b1};
    any_high = |(act & act_prio) | periph_high_pending |
               (main[B_PCF] & main[B_PCE] & sec[B_PCP]);
    any_low  = |(act & ~act_prio) | periph_low_pending |
               (main[B_PCF] & main[B_PCE] & ~sec[B_PCP]);
    if (rcc[B_PRIO])
    begin
      irq_high = main[B_GIE] & any_high;
      irq_low  = main[B_GIE] & main[B_PERIPHERAL_IRQ_ENABLE] & any_low;
    end
    else
    begin
      irq_high = main[B_GIE] & ((|act) | (main[B_PCF] & main[B_PCE]) |
                 (main[B_PERIPHERAL_IRQ_ENABLE] & (periph_high_pending | periph_low_pending)));
      irq_low  = 1'b0;
    end
    // Wake ignores the global enable
    wake_request = (|act) | (main[B_PCF] & main[B_PCE]);
  end

  // Hardware return stack and fast shadow copy
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  logic [SP_W-1:0] next_sp;
  irqrf_ctx_s      next_shadow;
  logic            push;
  logic            pop;

  always_comb
  begin
    // Full stack drops the push rather than wrapping
    push        = irq_entry && (sp != SP_FULL);
    pop         = irq_return && !irq_entry && (sp != '0);
    next_sp     = push ? sp + SP_ONE : (pop ? sp - SP_ONE : sp);
    next_shadow = irq_entry ? core_ctx : shadow_ctx;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sp         <= '0;
      shadow_ctx <= '0;
    end
    else
    begin
      sp         <= next_sp;
      shadow_ctx <= next_shadow;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      stack_mem[sp] <= return_pc;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      stack_top_pc <= '0;
    else if (push)
      stack_top_pc <= return_pc;
    else if (pop)
      stack_top_pc <= (sp > SP_ONE) ? stack_mem[SP_W'(sp - 2'h2)] : '0;
  end

  // Read port: data one cycle after the strobe, zero elsewhere
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = '0;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        OFF_RCC:   next_rdata = rcc_view;
        OFF_MAIN:  next_rdata = main;
        OFF_SEC:   next_rdata = sec;
        OFF_THIRD: next_rdata = third;
        OFF_CPEA:  next_rdata = cpe_a;
        OFF_CPEB:  next_rdata = cpe_b;
        OFF_STKP:  next_rdata = 8'(sp);
        default:   next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      bus_rdata <= '0;
    else
      bus_rdata <= next_rdata;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_prio_reset: assert property ($fell(rst) |-> !rcc[B_PRIO])
    else $error("priority enable not clear after reset");
  a_sbor_mode: assert property (brownout_mode_field != BOR_MODE_SW
                                |-> !sw_brownout_active)
    else $error("software brown-out active outside mode 01");
  a_ri_clear: assert property (reset_instr_exec |=> !rcc[B_RI])
    else $error("reset instruction flag not cleared");
  a_to_expiry: assert property (watchdog_expiry |=> !rcc[B_TO])
    else $error("watchdog flag not cleared on expiry");
  a_pd_sleep: assert property (sleep_instr |=> !rcc[B_PD] && rcc[B_TO])
    else $error("sleep did not clear power-down flag");
  a_bor_event: assert property (brownout_reset |=> !rcc[B_BOR])
    else $error("brown-out status not cleared");
  a_ext_flag: assert property (ext_edge[0] |=> main[B_E0F])
    else $error("external flag not set by edge");
  a_ext_edge: assert property (sec[B_EDG0] && $stable(sec[B_EDG0]) &&
                               pin_lvl[0] && !$past(pin_lvl[0])
                               |-> $past(ext_edge[0]))
    else $error("rising edge missed");
  a_gate_req: assert property (!main[B_GIE] |-> !irq_high && !irq_low)
    else $error("request without global enable");
  a_timer_flag: assert property (timer_wrap |=> main[B_TOF])
    else $error("timer wrap lost");
  a_legacy_low: assert property (!rcc[B_PRIO] |-> !irq_low)
    else $error("low request in single level mode");
  a_ext_irq_zero_high: assert property (rcc[B_PRIO] && main[B_GIE] && act[0]
                                |-> irq_high)
    else $error("pin 0 not high priority");
  a_push_stack: assert property (push |=> stack_top_pc == $past(return_pc)
                                 && sp == $past(sp) + SP_ONE)
    else $error("return address not pushed");
  a_shadow_copy: assert property (irq_entry |=> shadow_ctx == $past(core_ctx))
    else $error("shadow context not captured");
  a_wake_ext: assert property (act[1] |-> wake_request)
    else $error("enabled pin did not wake");

  c_ext_irq: cover property (ext_edge[1] ##[1:4] irq_high);
  c_port_chg: cover property (port_mismatch ##1 main[B_PCF]);
  c_low_prio: cover property (irq_low);
  c_entry: cover property (irq_entry ##[1:20] irq_return);
endmodule : irqrf_top

// ===== tb/irqrf_core_model.sv
// Purpose: Core stand-in that takes and leaves interrupts
// Assumes: Requests are levels on clock
// Notes:   Fixed return address and context, so a stale capture shows
`timescale 1ns/100ps
module irqrf_core_model
  import irqrf_pkg::*;
#(
  parameter int              PC_W   = 21,
  parameter logic [PC_W-1:0] RET_PC = 21'h0abcde,
  parameter irqrf_ctx_s      CTX    = 24'h5a3c96
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       irq_high,
  input  wire logic       irq_low,
  output logic            irq_entry,
  output logic            irq_return,
  output logic [PC_W-1:0] return_pc,
  output irqrf_ctx_s      core_ctx
);
  logic pend;
  logic pend_q;
  assign pend      = irq_high | irq_low;
  assign return_pc = RET_PC;
  assign core_ctx  = CTX;
  // One entry per request; leaves only once software dropped the source
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pend_q     <= 1'b0;
      irq_entry  <= 1'b0;
      irq_return <= 1'b0;
    end
    else
    begin
      pend_q     <= pend;
      irq_entry  <= pend & ~pend_q;
      irq_return <= ~pend & pend_q;
    end
  end
endmodule : irqrf_core_model

// ===== tb/irqrf_top_test.sv
// Purpose: Register-level test of interrupt sources and reset flags
// Assumes: Core model answers every request rise
// Notes:   Pin waits of 6 cycles cover the 3-flop sync plus flag edge
`timescale 1ns/100ps
module irqrf_top_test;
  import irqrf_pkg::*;
  localparam int         PC_W   = 21;
  localparam logic [20:0] RET_PC = 21'h0abcde;
  localparam irqrf_ctx_s CTX    = 24'h5a3c96;
  logic            clock = 1'b0;
  logic            rst = 1'b1;
  irqrf_req_s      bus_req = '0;
  logic [7:0]      bus_rdata;
  logic [1:0]      mode = 2'h1;
  logic [6:0]      ev = 7'h00;
  logic [2:0]      pins = 3'h0;
  logic [7:0]      pa = 8'h00;
  logic [7:0]      pb = 8'h00;
  logic [15:0]     tcnt = 16'h0005;
  logic            wide = 1'b0;
  logic            phigh = 1'b0;
  logic            plow = 1'b0;
  logic            entry;
  logic            ret;
  logic [PC_W-1:0] rpc;
  logic [PC_W-1:0] top_pc;
  irqrf_ctx_s      cctx;
  irqrf_ctx_s      sctx;
  logic            irq_high;
  logic            irq_low;
  logic            wake;
  logic            swbor;
  int              n_mismatch = 0;
  int              total_checks = 0;

  always #50 clock = ~clock;

  irqrf_top #(.PC_W(PC_W), .STACK_DEPTH(31)) irqrf_top_inst (
    .clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .brownout_mode_field(mode), .reset_instr_exec(ev[0]), .watchdog_expiry(ev[1]),
    .watchdog_clear_instr(ev[2]), .sleep_instr(ev[3]), .brownout_reset(ev[4]),
    .ext_irq_pins(pins), .port_a_pins(pa), .port_b_pins(pb), .port_a_access(ev[5]),
    .port_b_access(ev[6]), .timer_count(tcnt), .timer_wide_mode(wide),
    .periph_high_pending(phigh), .periph_low_pending(plow), .irq_entry(entry),
    .irq_return(ret), .return_pc(rpc), .core_ctx(cctx), .irq_high(irq_high),
    .irq_low(irq_low), .wake_request(wake), .sw_brownout_active(swbor),
    .stack_top_pc(top_pc), .shadow_ctx(sctx));

  irqrf_core_model #(.PC_W(PC_W), .RET_PC(RET_PC), .CTX(CTX)) irqrf_core_model_inst (
    .clock(clock), .rst(rst), .irq_high(irq_high), .irq_low(irq_low),
    .irq_entry(entry), .irq_return(ret), .return_pc(rpc), .core_ctx(cctx));

  task end_sim;
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task chk24(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk24

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= {1'b1, 1'b0, a, d};
    @(posedge clock);
    bus_req <= '0;
  endtask : wr

  task rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    bus_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    bus_req <= '0;
    @(negedge clock);
    chk8(bus_rdata & m, e);
  endtask : rchk

  task qchk(input logic [7:0] e);
    @(negedge clock);
    chk8({6'h0, irq_high, irq_low}, e);
  endtask : qchk

  task pulse(input int k);
    @(posedge clock);
    ev[k] <= 1'b1;
    @(posedge clock);
    ev[k] <= 1'b0;
  endtask : pulse

  task setpin(input int i, input logic l);
    @(posedge clock);
    pins[i] <= l;
    repeat (6) @(posedge clock);
  endtask : setpin

  // Enables stay off: the flag must still follow the edge
  task ext_step(input int i, input logic l, input logic e);
    setpin(i, l);
    if (i == 0)
      rchk(OFF_MAIN, 8'h02, {6'h0, e, 1'b0});
    else
      rchk(OFF_THIRD, 8'h03, (i == 1) ? {7'h0, e} : {6'h0, e, 1'b0});
    wr(OFF_MAIN, 8'h00);
    wr(OFF_THIRD, 8'h00);
  endtask : ext_step

  task tick(input logic [15:0] a, input logic [15:0] b, input logic [7:0] e);
    @(posedge clock);
    tcnt <= a;
    @(posedge clock);
    tcnt <= b;
    repeat (2) @(posedge clock);
    rchk(OFF_MAIN, 8'h04, e);
    wr(OFF_MAIN, 8'h00);
  endtask : tick

  task port_wait(input logic [7:0] a, input logic [7:0] b, input logic [7:0] e);
    @(posedge clock);
    pa <= a;
    pb <= b;
    repeat (6) @(posedge clock);
    rchk(OFF_MAIN, 8'h01, e);
  endtask : port_wait

  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rchk(OFF_RCC, 8'hff, 8'h5c);
    rchk(OFF_MAIN, 8'hff, 8'h00);
    rchk(OFF_SEC, 8'hff, 8'h75);
    rchk(OFF_THIRD, 8'hff, 8'hc0);
    wr(3'h7, 8'hff);
    rchk(3'h7, 8'hff, 8'h00);
    @(posedge clock);
    mode <= 2'h0;
    rchk(OFF_RCC, 8'h40, 8'h00);
    chk8({7'h0, swbor}, 8'h00);
    @(posedge clock);
    mode <= 2'h2;
    @(negedge clock);
    chk8({7'h0, swbor}, 8'h00);
    @(posedge clock);
    mode <= 2'h1;
    @(negedge clock);
    chk8({7'h0, swbor}, 8'h01);
    wr(OFF_RCC, 8'h13);
    rchk(OFF_RCC, 8'hff, 8'h1f);
    chk8({7'h0, swbor}, 8'h00);
    wr(OFF_RCC, 8'h53);
    pulse(1);
    rchk(OFF_RCC, 8'h08, 8'h00);
    pulse(3);
    rchk(OFF_RCC, 8'h0c, 8'h08);
    pulse(2);
    rchk(OFF_RCC, 8'h0c, 8'h0c);
    pulse(0);
    rchk(OFF_RCC, 8'h10, 8'h00);
    pulse(4);
    rchk(OFF_RCC, 8'h03, 8'h02);
    wr(OFF_SEC, 8'h75);
    for (int i = 0; i < 3; i++)
    begin
      ext_step(i, 1'b1, 1'b1);
      ext_step(i, 1'b0, 1'b0);
      wr(OFF_SEC, SEC_RESET & ~(8'h40 >> i));
      ext_step(i, 1'b1, 1'b0);
      ext_step(i, 1'b0, 1'b1);
      wr(OFF_SEC, SEC_RESET);
    end
    wr(OFF_RCC, 8'h53);
    wr(OFF_MAIN, 8'h90);
    @(posedge clock);
    pins[0] <= 1'b1;
    for (int k = 0; k < 20 && irq_high !== 1'b1; k++)
      @(negedge clock);
    if (irq_high !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] %0t request never raised", $time);
      end_sim;
    end
    qchk(8'h02);
    repeat (4) @(posedge clock);
    chk24({3'h0, top_pc}, {3'h0, RET_PC});
    chk24(sctx, CTX);
    rchk(OFF_STKP, 8'hff, 8'h01);
    wr(OFF_MAIN, 8'h82);
    qchk(8'h00);
    wr(OFF_MAIN, 8'h12);
    qchk(8'h00);
    chk8({7'h0, wake}, 8'h01);
    wr(OFF_MAIN, 8'h92);
    qchk(8'h02);
    wr(OFF_MAIN, 8'h00);
    repeat (4) @(posedge clock);
    chk24({3'h0, top_pc}, 24'h000000);
    rchk(OFF_STKP, 8'hff, 8'h00);
    wr(OFF_RCC, 8'hd3);
    wr(OFF_THIRD, 8'h18);
    wr(OFF_MAIN, 8'h80);
    setpin(1, 1'b1);
    qchk(8'h00);
    wr(OFF_MAIN, 8'hc0);
    qchk(8'h01);
    wr(OFF_THIRD, 8'h59);
    qchk(8'h02);
    wr(OFF_THIRD, 8'h18);
    wr(OFF_SEC, 8'h35);
    wr(OFF_MAIN, 8'hd0);
    setpin(0, 1'b0);
    qchk(8'h02);
    wr(OFF_SEC, 8'h75);
    wr(OFF_MAIN, 8'he0);
    tick(16'h00ff, 16'h0100, 8'h04);
    wr(OFF_MAIN, 8'he4);
    qchk(8'h02);
    wr(OFF_SEC, 8'h71);
    qchk(8'h01);
    wr(OFF_MAIN, 8'h00);
    @(posedge clock);
    wide <= 1'b1;
    tick(16'h00ff, 16'h0100, 8'h00);
    tick(16'hffff, 16'h0000, 8'h04);
    @(posedge clock);
    wide <= 1'b0;
    tick(16'h12fe, 16'h12ff, 8'h00);
    wr(OFF_CPEA, 8'h01);
    wr(OFF_CPEB, 8'h80);
    pulse(5);
    pulse(6);
    wr(OFF_MAIN, 8'h00);
    port_wait(8'h02, 8'h01, 8'h00);
    port_wait(8'h03, 8'h01, 8'h01);
    wr(OFF_SEC, 8'h74);
    wr(OFF_MAIN, 8'hc9);
    qchk(8'h01);
    wr(OFF_SEC, 8'h75);
    qchk(8'h02);
    wr(OFF_MAIN, 8'h41);
    qchk(8'h00);
    pulse(5);
    wr(OFF_MAIN, 8'h00);
    port_wait(8'h03, 8'h01, 8'h00);
    port_wait(8'h03, 8'h81, 8'h01);
    pulse(6);
    wr(OFF_MAIN, 8'h00);
    wr(OFF_RCC, 8'h53);
    wr(OFF_MAIN, 8'h80);
    @(posedge clock);
    phigh <= 1'b1;
    qchk(8'h00);
    wr(OFF_MAIN, 8'hc0);
    qchk(8'h02);
    @(posedge clock);
    phigh <= 1'b0;
    plow  <= 1'b1;
    qchk(8'h02);
    wr(OFF_RCC, 8'hd3);
    qchk(8'h01);
    // Second power-on reset in mid-run
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rchk(OFF_RCC, 8'hff, 8'h5c);
    rchk(OFF_MAIN, 8'hff, 8'h00);
    qchk(8'h00);
    end_sim;
  end
endmodule : irqrf_top_test
